/* File: rtl/sep_top.sv */
// serial eeprom instruction decode, write latch, protection and array
// assumes the link pins are asynchronous and slow against mclk
// (serial clock period at least eight mclk periods)
`timescale 1ns/10ps
`include "sep_params.svh"
module sep_top #(
  parameter int unsigned WC_CYCLES = `SEP_TWC_CYC
) (
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic SCK,
  input wire logic CS_B,
  input wire logic SI,
  input wire logic WP_B,
  output logic SO,
  output logic SO_OE,
  output logic BUSY,
  output logic [7:0] STATUS
);
  import sep_pkg::*;

  sep_st_t st_r;
  sep_st_t st_nxt;
  sep_pins_t pins_raw;
  sep_pins_t pins_s;
  logic tmr_busy;
  logic tmr_done;
  logic [7:0] mem [0:(1 << `SEP_AW) - 1];
  logic [7:0] rd_byte;
  logic [7:0] stat_byte;
  logic [`SEP_AW-1:0] cm_addr;
  logic cm_we;

  function automatic logic is_prot(input logic [1:0] bp, input logic [`SEP_AW-1:0] a);
    logic r;
    r = 1'b0;
    if (bp == 2'h3) begin
      r = 1'b1;
    end else if (bp == 2'h2) begin
      r = (a >= `SEP_Q2_BASE);
    end else if (bp == 2'h1) begin
      r = (a >= `SEP_Q1_BASE);
    end
    return r;
  endfunction

  // whole-array step; the top location rolls over to zero
  function automatic logic [`SEP_AW-1:0] next_addr(input logic [`SEP_AW-1:0] a);
    return a + 13'h1;
  endfunction

  // upper nibble must be zero; bit 3 is don't-care
  function automatic logic op_is(input logic [7:0] b, input logic [2:0] code);
    return (b[7:4] == 4'h0) && (b[2:0] == code);
  endfunction

  assign pins_raw.sck = SCK;
  assign pins_raw.cs_b = CS_B;
  assign pins_raw.si = SI;
  assign pins_raw.wp_b = WP_B;

  sep_sync u_sync (
    .mclk(MCLK),
    .rst_b(RST_B),
    .d(pins_raw),
    .q(pins_s)
  );

  sep_wtimer #(
    .CYCLES(WC_CYCLES)
  ) u_tmr (
    .mclk(MCLK),
    .rst_b(RST_B),
    .start(st_r.start),
    .busy(tmr_busy),
    .done(tmr_done)
  );

  // status shows committed values only; ready bit follows the timer
  always_comb begin
    stat_byte = 8'h00;
    stat_byte[`SEP_SR_RDY] = tmr_busy;
    stat_byte[`SEP_SR_WEL] = st_r.wel;
    stat_byte[`SEP_SR_BPL] = st_r.bp[0];
    stat_byte[`SEP_SR_BPH] = st_r.bp[1];
    stat_byte[`SEP_SR_PIN] = st_r.pin_honour_bit;
  end

  assign rd_byte = mem[st_r.addr];

  // page commit walks one buffered byte per cycle during the write cycle
  assign cm_addr = {st_r.addr[`SEP_AW-1:5], st_r.cidx[4:0]};
  assign cm_we = st_r.wr_act && !st_r.cidx[5] && st_r.pmask[st_r.cidx[4:0]]
    && !is_prot(st_r.bp, cm_addr);

  always_ff @(posedge MCLK) begin
    if (cm_we) begin
      mem[cm_addr] <= st_r.pbuf[st_r.cidx[4:0]];
    end
  end

  always_comb begin
    logic rise;
    logic fall;
    logic cs_up;
    logic hwp;
    logic [7:0] b;
    rise = 1'b0;
    fall = 1'b0;
    cs_up = 1'b0;
    hwp = 1'b0;
    b = 8'h00;
    st_nxt = st_r;
    st_nxt.start = 1'b0;
    st_nxt.pins_d = pins_s;
    rise = pins_s.sck && !st_r.pins_d.sck;
    fall = !pins_s.sck && st_r.pins_d.sck;
    cs_up = pins_s.cs_b && !st_r.pins_d.cs_b;
    hwp = st_r.pin_honour_bit && !pins_s.wp_b;
    b = {st_r.shin, pins_s.si};

    if (st_r.wr_act && !st_r.cidx[5]) begin
      st_nxt.cidx = st_r.cidx + 6'h1;
    end

    // status stays old until the cycle ends, then all updates land
    if (tmr_done) begin
      if (st_r.sw_act) begin
        st_nxt.bp = st_r.sw_bp;
        st_nxt.pin_honour_bit = st_r.sw_pin_honour_bit;
      end
      st_nxt.wel = 1'b0;
      st_nxt.wr_act = 1'b0;
      st_nxt.sw_act = 1'b0;
    end

    // launch on select rising, only after whole bytes
    if (cs_up && st_r.bitcnt == 3'h0 && !tmr_busy) begin
      case (st_r.pend)
        SEP_P_SET: begin
          st_nxt.wel = 1'b1;
        end
        SEP_P_CLR: begin
          st_nxt.wel = 1'b0;
        end
        SEP_P_SW: begin
          if (st_r.wel && !hwp) begin
            st_nxt.sw_act = 1'b1;
            st_nxt.start = 1'b1;
            // pin-honour may only fall while the protect pin is high
            st_nxt.sw_pin_honour_bit = st_r.sw_pin_honour_bit || (st_r.pin_honour_bit && !pins_s.wp_b);
          end
        end
        SEP_P_WR: begin
          if (st_r.wel) begin
            st_nxt.wr_act = 1'b1;
            st_nxt.cidx = 6'h00;
            st_nxt.start = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end

    if (pins_s.cs_b) begin
      // deselect ends any read or pending decode
      st_nxt.state = SEP_OPC;
      st_nxt.bitcnt = 3'h0;
      st_nxt.acnt = 1'b0;
      st_nxt.so_oe = 1'b0;
      st_nxt.pend = SEP_P_NONE;
    end else begin
      if (rise) begin
        st_nxt.bitcnt = st_r.bitcnt + 3'h1;
        st_nxt.shin = b[6:0];
        if (st_r.bitcnt == 3'h7) begin
          case (st_r.state)
            SEP_OPC: begin
              st_nxt.state = SEP_SKIP;
              if (op_is(b, `SEP_OPC_STAT_RD)) begin
                st_nxt.state = SEP_STOUT;
                st_nxt.outsh = stat_byte;
              end else if (tmr_busy) begin
                st_nxt.state = SEP_SKIP;
              end else if (op_is(b, `SEP_OPC_LATCH_SET)) begin
                st_nxt.pend = SEP_P_SET;
              end else if (op_is(b, `SEP_OPC_LATCH_CLR)) begin
                st_nxt.pend = SEP_P_CLR;
              end else if (op_is(b, `SEP_OPC_STAT_WR)) begin
                st_nxt.state = SEP_SWDATA;
              end else if (op_is(b, `SEP_OPC_ARR_RD)) begin
                st_nxt.state = SEP_ADDR;
                st_nxt.pend = SEP_P_NONE;
              end else if (op_is(b, `SEP_OPC_ARR_WR)) begin
                st_nxt.state = SEP_ADDR;
                st_nxt.pend = SEP_P_WR;
              end
              st_nxt.acnt = 1'b0;
            end
            SEP_ADDR: begin
              st_nxt.acnt = 1'b1;
              if (!st_r.acnt) begin
                st_nxt.addr[`SEP_AW-1:8] = b[`SEP_AW-9:0];
              end else begin
                st_nxt.addr[7:0] = b;
                if (st_r.pend == SEP_P_WR) begin
                  // no write launches until a data byte arrives
                  st_nxt.pend = SEP_P_NONE;
                  st_nxt.pmask = '0;
                  st_nxt.state = SEP_WDATA;
                end else begin
                  st_nxt.state = SEP_RDOUT;
                  st_nxt.outsh = mem[{st_r.addr[`SEP_AW-1:8], b}];
                  st_nxt.addr = next_addr({st_r.addr[`SEP_AW-1:8], b});
                end
              end
            end
            SEP_WDATA: begin
              // later bytes overwrite earlier ones at the same slot
              st_nxt.pbuf[st_r.addr[4:0]] = b;
              st_nxt.pmask[st_r.addr[4:0]] = 1'b1;
              st_nxt.addr[4:0] = st_r.addr[4:0] + 5'h1;
              st_nxt.pend = SEP_P_WR;
            end
            SEP_RDOUT: begin
              st_nxt.outsh = rd_byte;
              st_nxt.addr = next_addr(st_r.addr);
            end
            SEP_STOUT: begin
              st_nxt.outsh = stat_byte;
            end
            SEP_SWDATA: begin
              st_nxt.sw_bp = {b[`SEP_SR_BPH], b[`SEP_SR_BPL]};
              st_nxt.sw_pin_honour_bit = b[`SEP_SR_PIN];
              st_nxt.pend = SEP_P_SW;
              st_nxt.state = SEP_SKIP;
            end
            default: begin
              // extra bytes after a complete command spoil it
              st_nxt.pend = SEP_P_NONE;
            end
          endcase
        end
      end
      if (fall && (st_r.state == SEP_RDOUT || st_r.state == SEP_STOUT)) begin
        st_nxt.so = st_r.outsh[7];
        st_nxt.so_oe = 1'b1;
        st_nxt.outsh = {st_r.outsh[6:0], 1'b0};
      end
    end
  end

  // latch clear at reset: nothing writable until latch-set
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      st_r <= '0;
      st_r.pins_d.cs_b <= 1'b1;
      st_r.pins_d.wp_b <= 1'b1;
      st_r.bp <= `SEP_BP_RST;
      st_r.pin_honour_bit <= `SEP_PIN_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign SO = st_r.so;
  assign SO_OE = st_r.so_oe;
  assign BUSY = tmr_busy;
  assign STATUS = stat_byte;
endmodule

/* File: rtl/sep_params.svh */
// constants of the serial eeprom command and protection block
// assumes a 25 MHz core clock and an externally driven serial link
`ifndef SEP_PARAMS_SVH
`define SEP_PARAMS_SVH
`define SEP_AW 13
`define SEP_PAGE_BYTES 32
`define SEP_OPC_LATCH_SET 3'h6
`define SEP_OPC_LATCH_CLR 3'h4
`define SEP_OPC_STAT_RD 3'h5
`define SEP_OPC_STAT_WR 3'h1
`define SEP_OPC_ARR_RD 3'h3
`define SEP_OPC_ARR_WR 3'h2
`define SEP_SR_RDY 0
`define SEP_SR_WEL 1
`define SEP_SR_BPL 2
`define SEP_SR_BPH 3
`define SEP_SR_PIN 7
`define SEP_BP_RST 2'h0
`define SEP_PIN_RST 1'b0
`define SEP_Q1_BASE 13'h1800
`define SEP_Q2_BASE 13'h1000
`define SEP_TWC_MS 5
`define SEP_MCLK_HZ 25000000
`define SEP_TWC_CYC ((`SEP_TWC_MS * `SEP_MCLK_HZ) / 1000)
`endif

/* File: rtl/sep_pkg.sv */
// types shared by the serial eeprom block
// assumes sep_params.svh for the address and page widths
`include "sep_params.svh"
package sep_pkg;
  typedef enum logic [2:0] {
    SEP_OPC = 3'h0,
    SEP_ADDR = 3'h1,
    SEP_WDATA = 3'h3,
    SEP_RDOUT = 3'h2,
    SEP_STOUT = 3'h6,
    SEP_SWDATA = 3'h7,
    SEP_SKIP = 3'h5
  } sep_state_t;
  typedef enum logic [2:0] {
    SEP_P_NONE, SEP_P_SET, SEP_P_CLR, SEP_P_SW, SEP_P_WR
  } sep_pend_t;
  typedef struct packed {
    logic sck;
    logic cs_b;
    logic si;
    logic wp_b;
  } sep_pins_t;
  typedef struct packed {
    sep_state_t state;
    sep_pins_t pins_d;
    logic [2:0] bitcnt;
    logic [6:0] shin;
    logic acnt;
    logic [`SEP_AW-1:0] addr;
    logic [7:0] outsh;
    logic so;
    logic so_oe;
    sep_pend_t pend;
    logic wel;
    logic [1:0] bp;
    logic pin_honour_bit;
    logic [1:0] sw_bp;
    logic sw_pin_honour_bit;
    logic [`SEP_PAGE_BYTES-1:0] pmask;
    logic [`SEP_PAGE_BYTES-1:0][7:0] pbuf;
    logic wr_act;
    logic sw_act;
    logic [5:0] cidx;
    logic start;
  } sep_st_t;
endpackage

/* File: rtl/sep_sync.sv */
// two-stage synchroniser for the serial link pins
// assumes pins are asynchronous to mclk
`timescale 1ns/10ps
module sep_sync (
  input wire logic mclk,
  input wire logic rst_b,
  input wire sep_pkg::sep_pins_t d,
  output sep_pkg::sep_pins_t q
);
  import sep_pkg::*;
  typedef struct packed {
    sep_pins_t s1;
    sep_pins_t s2;
  } sep_sync_st_t;
  sep_sync_st_t st_r;
  sep_sync_st_t st_nxt;
  always_comb begin
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
  end
  // idle pins: clock low, select high, protect pin high
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= 8'h55;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign q = st_r.s2;
endmodule

/* File: rtl/sep_wtimer.sv */
// internal write cycle timer: busy for a set count after start
// assumes start is a one-cycle pulse on mclk
`timescale 1ns/10ps
`include "sep_params.svh"
module sep_wtimer #(
  parameter int unsigned CYCLES = `SEP_TWC_CYC
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic start,
  output logic busy,
  output logic done
);
  import sep_pkg::*;
  typedef struct packed {
    logic [23:0] cnt;
    logic busy;
    logic done;
  } sep_tmr_st_t;
  sep_tmr_st_t st_r;
  sep_tmr_st_t st_nxt;
  always_comb begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    if (start && !st_r.busy) begin
      st_nxt.cnt = 24'(CYCLES);
      st_nxt.busy = 1'b1;
    end else if (st_r.busy) begin
      st_nxt.cnt = st_r.cnt - 24'h1;
      if (st_r.cnt == 24'h1) begin
        st_nxt.busy = 1'b0;
        st_nxt.done = 1'b1;
      end
    end
  end
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign busy = st_r.busy;
  assign done = st_r.done;
endmodule

/* File: tb/sep_top_monitor.sv */
// assertions on the ports of the serial eeprom block
// assumes one mclk domain and a host holding cs_b high between frames
`timescale 1ns/10ps
module sep_top_monitor #(
  parameter int unsigned WC_CYCLES = 64
) (
  input wire logic MCLK,
  input wire logic RST_B,
  input wire logic SCK,
  input wire logic CS_B,
  input wire logic SI,
  input wire logic WP_B,
  input wire logic SO,
  input wire logic SO_OE,
  input wire logic BUSY,
  input wire logic [7:0] STATUS
);
  logic [31:0] busy_cnt_r;
  logic [31:0] busy_cnt_nxt;
  always_comb busy_cnt_nxt = BUSY ? busy_cnt_r + 32'h1 : 32'h0;
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      busy_cnt_r <= 32'h0;
    end else begin
      busy_cnt_r <= busy_cnt_nxt;
    end
  end
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RST_B);
  a_ready_bit_mirror: assert property (STATUS[0] == BUSY)
    else $error("status ready bit differs from busy");
  a_busy_full_length: assert property ($fell(BUSY) |-> busy_cnt_r == WC_CYCLES)
    else $error("write cycle length wrong");
  a_unused_bits_zero: assert property (STATUS[6:4] == 3'h0)
    else $error("unstored status bits not zero");
  a_launch_on_deselect: assert property ($rose(BUSY) |-> CS_B)
    else $error("write cycle began while selected");
  a_read_ends_cs: assert property ($rose(CS_B) |-> ##[1:6] !SO_OE)
    else $error("output still driven after deselect");
  a_latch_set_idle: assert property ($rose(STATUS[1]) |-> CS_B && !BUSY)
    else $error("latch set while selected or busy");
  a_latch_clear_end: assert property ($fell(BUSY) |-> ##[0:2] !STATUS[1])
    else $error("latch not cleared after write cycle");
  a_prot_bits_hold: assert property ($changed({STATUS[7], STATUS[3:2]}) |->
    !BUSY && ($past(BUSY) || $past(BUSY, 2)))
    else $error("protect bits changed outside write end");
  a_pin_bit_drop: assert property ($fell(STATUS[7]) |-> WP_B)
    else $error("pin honour bit dropped with protect pin low");
  c_write_cycle: cover property ($fell(BUSY));
  c_read_out: cover property ($rose(SO_OE));
  c_pin_drop: cover property ($fell(STATUS[7]));
endmodule
bind sep_top sep_top_monitor #(.WC_CYCLES(WC_CYCLES)) u_sep_top_monitor (
  .MCLK(MCLK), .RST_B(RST_B), .SCK(SCK), .CS_B(CS_B), .SI(SI), .WP_B(WP_B),
  .SO(SO), .SO_OE(SO_OE), .BUSY(BUSY), .STATUS(STATUS));

/* File: tb/sep_host_model.sv */
// spi host model driving the serial link of the eeprom block
// assumes mclk at 25 MHz; serial clock runs only inside frames
`timescale 1ns/10ps
module sep_host_model (
  input wire logic mclk,
  output logic sck,
  output logic cs_b,
  output logic si,
  input wire logic so
);
  initial begin
    sck = 1'b0;
    cs_b = 1'b1;
    si = 1'b0;
  end
  task automatic h(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // so sampled mid-high, well away from its change after the fall
  task automatic xb(input logic [7:0] d, output logic [7:0] q);
    for (int i = 7; i >= 0; i--) begin
      si = d[i];
      h(4);
      sck = 1'b1;
      h(2);
      q[i] = so;
      h(2);
      sck = 1'b0;
    end
  endtask
  task automatic sel();
    cs_b = 1'b0;
    h(4);
  endtask
  // released data line flips so nothing leans on a stale bit
  task automatic desel();
    h(4);
    cs_b = 1'b1;
    si = ~si;
    h(8);
  endtask
endmodule

/* File: tb/sep_top_tb_top.sv */
// self-checking bench for the serial eeprom block over its serial link
// assumes the host model drives the link; write cycle shortened to WC
`timescale 1ns/10ps
module sep_top_tb_top;
  import sep_pkg::*;
  localparam int unsigned WC = 400;
  logic mclk, rst_b, wp_b, so, so_oe, busy, sck, cs_b, si;
  logic [7:0] status;
  logic so_line;
  logic [7:0] q;
  logic [7:0] rb [0:3];
  int num_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  sep_top #(.WC_CYCLES(WC)) u_sep_top (.MCLK(mclk), .RST_B(rst_b), .SCK(sck), .CS_B(cs_b),
    .SI(si), .WP_B(wp_b), .SO(so), .SO_OE(so_oe), .BUSY(busy), .STATUS(status));
  // released output shows the inverse of its last bit, so a missing enable shows up
  assign so_line = so_oe ? so : ~so;
  sep_host_model u_sep_host_model (.mclk(mclk), .sck(sck), .cs_b(cs_b), .si(si), .so(so_line));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic op1(input logic [7:0] c);
    u_sep_host_model.sel();
    u_sep_host_model.xb(c, q);
    u_sep_host_model.desel();
  endtask
  task automatic wait_rdy();
    int i;
    i = 0;
    while (busy !== 1'b0 && i < 4 * WC) begin
      @(posedge mclk);
      #1;
      i++;
    end
    // latch and protect bits land one edge after busy drops
    repeat (2) @(posedge mclk);
    #1;
    chk("busy_end", 8'h00, {7'h0, busy});
  endtask
  // write with or without a latch set first; caller waits for ready
  task automatic wr(input logic en, input logic [15:0] a, input int n, input logic [7:0] d0);
    if (en) op1(8'h06);
    u_sep_host_model.sel();
    u_sep_host_model.xb(8'h02, q);
    u_sep_host_model.xb(a[15:8], q);
    u_sep_host_model.xb(a[7:0], q);
    for (int i = 0; i < n; i++) u_sep_host_model.xb(d0 + i[7:0], q);
    u_sep_host_model.desel();
    chk("busy_wr", {7'h0, en}, {7'h0, busy});
  endtask
  task automatic status_write_cmd(input logic [7:0] v);
    op1(8'h06);
    u_sep_host_model.sel();
    u_sep_host_model.xb(8'h01, q);
    u_sep_host_model.xb(v, q);
    u_sep_host_model.desel();
  endtask
  task automatic rd(input logic [15:0] a, input int n);
    u_sep_host_model.sel();
    u_sep_host_model.xb(8'h03, q);
    u_sep_host_model.xb(a[15:8], q);
    u_sep_host_model.xb(a[7:0], q);
    for (int i = 0; i < n; i++) u_sep_host_model.xb(8'h00, rb[i]);
    u_sep_host_model.desel();
    chk("so_oe_end", 8'h00, {7'h0, so_oe});
  endtask
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      end_of_test();
    end
  end
  initial begin
    rst_b = 1'b0;
    wp_b = 1'b1;
    repeat (8) @(posedge mclk);
    #1;
    rst_b = 1'b1;
    chk("status_rst", 8'h00, status);
    chk("so_oe_rst", 8'h00, {7'h0, so_oe});
    repeat (4) @(posedge mclk);
    #1;
    op1(8'h0e);
    chk("latch_set", 8'h02, status);
    op1(8'h04);
    chk("latch_clr", 8'h00, status);
    $display("test latch done");
    wr(1'b1, 16'he01e, 3, 8'ha0);
    wait_rdy();
    chk("latch_after_wr", 8'h00, status);
    wr(1'b1, 16'hffff, 1, 8'h5b);
    wait_rdy();
    rd(16'h001e, 2);
    chk("page_1e", 8'ha0, rb[0]);
    chk("page_1f", 8'ha1, rb[1]);
    rd(16'h1fff, 2);
    chk("rd_1fff", 8'h5b, rb[0]);
    chk("rd_wrap_0", 8'ha2, rb[1]);
    $display("test page write done");
    wr(1'b0, 16'h001e, 1, 8'h11);
    rd(16'h001e, 1);
    chk("no_latch_wr", 8'ha0, rb[0]);
    $display("test read-only done");
    wr(1'b1, 16'h0040, 34, 8'h40);
    op1(8'h06);
    u_sep_host_model.sel();
    u_sep_host_model.xb(8'h05, q);
    u_sep_host_model.xb(8'h00, rb[0]);
    u_sep_host_model.xb(8'h00, rb[1]);
    u_sep_host_model.desel();
    chk("sr_busy_0", 8'h03, rb[0]);
    chk("sr_busy_1", 8'h03, rb[1]);
    wait_rdy();
    chk("latch_ignored", 8'h00, status);
    rd(16'h0040, 3);
    chk("ovf_0", 8'h60, rb[0]);
    chk("ovf_1", 8'h61, rb[1]);
    chk("ovf_2", 8'h42, rb[2]);
    $display("test overflow done");
    status_write_cmd(8'hf4);
    chk("sr_during", 8'h03, status);
    wait_rdy();
    chk("sr_stored", 8'h84, status);
    wp_b = 1'b0;
    wr(1'b1, 16'h1fff, 1, 8'h00);
    wait_rdy();
    wr(1'b1, 16'h0100, 1, 8'h77);
    wait_rdy();
    rd(16'h1fff, 1);
    chk("prot_kept", 8'h5b, rb[0]);
    rd(16'h0100, 1);
    chk("hw_no_array", 8'h77, rb[0]);
    status_write_cmd(8'h00);
    wait_rdy();
    chk("sr_hw_prot", 8'h84, status & 8'h8c);
    wp_b = 1'b1;
    status_write_cmd(8'h00);
    wait_rdy();
    chk("sr_pin_drop", 8'h00, status);
    $display("test protection done");
    end_of_test();
  end
endmodule
